// >>> rtl/emp_params.svh
// Constants of the external memory port: widths, address ranges, access timing.
// Assumes inclusion by bare name from the package and the port modules.
`ifndef EMP_PARAMS_SVH
`define EMP_PARAMS_SVH

`define EMP_ADDR_W 16
`define EMP_DATA_W 24
`define EMP_PERIPH_LO 16'hFFC0
`define EMP_PERIPH_HI 16'hFFFF
`define EMP_STROBE_CYCLES 2'h2
`define EMP_CNT_ZERO 2'h0
`define EMP_CNT_ONE 2'h1
`define EMP_ADDR_RESET 16'h0000
`define EMP_DATA_RESET 24'h000000

`endif

// >>> rtl/emp_pkg.sv
// Types shared by the external memory port modules.
// Assumes emp_params.svh is on the include path.
`default_nettype none
`include "emp_params.svh"

package emp_pkg;

    typedef enum logic [1:0] {
        EMP_SP_PROG,
        EMP_SP_X,
        EMP_SP_Y
    } emp_space_t;

    typedef struct packed {
        logic valid;
        logic write;
        emp_space_t space;
        logic vector_fetch;
        logic [`EMP_ADDR_W-1:0] addr;
        logic [`EMP_DATA_W-1:0] wdata;
    } emp_req_t;

    typedef struct packed {
        logic program_space_sel_n;
        logic data_space_sel_n;
        logic xy_sel;
        logic periph_space_sel_n;
    } emp_sel_t;

    typedef struct packed {
        logic done;
        logic [`EMP_DATA_W-1:0] rdata;
    } emp_rsp_t;

endpackage

`default_nettype wire

// >>> rtl/emp_select_decode.sv
// Select decoder: turns an access request into the space select levels.
// Assumes the caller registers the result and gates it with the access phase.
`timescale 1ns/1ps
`default_nettype none
`include "emp_params.svh"

module emp_select_decode (
    // Request.
    input wire emp_pkg::emp_req_t req,
    input wire logic dev_mode,
    // Select levels.
    output emp_pkg::emp_sel_t sel
);
    import emp_pkg::*;

    always_comb begin
        sel = '{program_space_sel_n: 1'b1, data_space_sel_n: 1'b1,
                xy_sel: 1'b1, periph_space_sel_n: 1'b1};
        if (req.valid) begin
            unique case (req.space)
                EMP_SP_X: begin
                    sel.data_space_sel_n = 1'b0;
                end
                EMP_SP_Y: begin
                    sel.data_space_sel_n = 1'b0;
                    sel.xy_sel = 1'b0;
                    if (req.addr >= `EMP_PERIPH_LO && req.addr <= `EMP_PERIPH_HI) begin
                        sel.periph_space_sel_n = 1'b0;
                    end
                end
                default: begin
                    // Program space; vector marking only in development mode.
                    sel.program_space_sel_n = 1'b0;
                    sel.xy_sel = !(req.vector_fetch && dev_mode);
                end
            endcase
        end
    end

endmodule

`default_nettype wire

// >>> rtl/emp_port.sv
// External memory port: address, data and strobe pins toward external memory.
// Assumes a core that holds req until done and a testbench that resolves the pins.
`timescale 1ns/1ps
`default_nettype none
`include "emp_params.svh"

// Behaviour
// - Idle bus keeps last address driven.
// - Idle bus releases the data pins.
// - Reset three-states every port pin.
// - Program select only on program accesses.
// - Data select only on data accesses.
// - Program select changes with the address.
// - X data: prog high, data low, xy high.
// - Y data: prog high, data low, xy low.
// - Program: prog low, data high, xy high.
// - Dev-mode vector fetch: prog low, xy low.
// - Read strobe low; data captured at deassertion.
// - Write strobe low drives data; memory latches.
// - Peripheral select for Y FFC0 to FFFF.
// - Active low asserts low, high asserts high.
module emp_port (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic nrst,
    // Core request and answer.
    input wire emp_pkg::emp_req_t req,
    input wire logic dev_mode,
    output emp_pkg::emp_rsp_t rsp,
    output logic req_ready,
    // Address bus.
    output logic [`EMP_ADDR_W-1:0] addr_out,
    output logic addr_out_oe,
    // Data bus.
    input wire logic [`EMP_DATA_W-1:0] mem_data_i,
    output logic [`EMP_DATA_W-1:0] mem_data_o,
    output logic mem_data_oe,
    // Selects and strobes, one enable for the whole control group.
    output logic program_space_sel_n,
    output logic data_space_sel_n,
    output logic xy_sel,
    output logic periph_space_sel_n,
    output logic rd_strobe_n,
    output logic wr_strobe_n,
    output logic ctrl_oe
);
    import emp_pkg::*;

    typedef enum logic [1:0] {
        EMP_ST_IDLE,
        EMP_ST_STROBE,
        EMP_ST_DONE
    } emp_state_t;

    typedef struct packed {
        emp_state_t st;
        logic [1:0] cnt;
        logic out_en;
        logic write;
        logic [`EMP_ADDR_W-1:0] addr;
        logic [`EMP_DATA_W-1:0] wdata;
        emp_sel_t sel;
        logic rd_n;
        logic wr_n;
        emp_rsp_t rsp;
    } emp_port_state_t;

    emp_port_state_t s_q, s_d;
    emp_sel_t dec_sel;
    emp_sel_t idle_sel;

    assign idle_sel = '{program_space_sel_n: 1'b1, data_space_sel_n: 1'b1,
                        xy_sel: 1'b1, periph_space_sel_n: 1'b1};

    emp_select_decode u_dec (
        .req(req),
        .dev_mode(dev_mode),
        .sel(dec_sel)
    );

    assign req_ready = (s_q.st == EMP_ST_IDLE) && s_q.out_en;

    always_comb begin
        s_d = s_q;
        s_d.out_en = 1'b1;
        s_d.rsp.done = 1'b0;
        unique case (s_q.st)
            EMP_ST_IDLE: begin
                s_d.sel = idle_sel;
                if (req.valid && s_q.out_en) begin
                    s_d.addr = req.addr;
                    s_d.sel = dec_sel;
                    s_d.write = req.write;
                    s_d.wdata = req.wdata;
                    s_d.rd_n = req.write;
                    s_d.wr_n = !req.write;
                    s_d.cnt = `EMP_STROBE_CYCLES;
                    s_d.st = EMP_ST_STROBE;
                end
            end
            EMP_ST_STROBE: begin
                s_d.cnt = s_q.cnt - `EMP_CNT_ONE;
                if (s_q.cnt == `EMP_CNT_ONE) begin
                    s_d.rd_n = 1'b1;
                    s_d.wr_n = 1'b1;
                    s_d.st = EMP_ST_DONE;
                    if (!s_q.write) begin
                        s_d.rsp.rdata = mem_data_i;
                    end
                end
            end
            EMP_ST_DONE: begin
                s_d.rsp.done = 1'b1;
                s_d.sel = idle_sel;
                s_d.st = EMP_ST_IDLE;
            end
            default: begin
                s_d.st = EMP_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            s_q <= '{st: EMP_ST_IDLE, cnt: `EMP_CNT_ZERO, out_en: 1'b0, write: 1'b0,
                     addr: `EMP_ADDR_RESET, wdata: `EMP_DATA_RESET,
                     sel: '{program_space_sel_n: 1'b1, data_space_sel_n: 1'b1,
                            xy_sel: 1'b1, periph_space_sel_n: 1'b1},
                     rd_n: 1'b1, wr_n: 1'b1,
                     rsp: '{done: 1'b0, rdata: `EMP_DATA_RESET}};
        end else begin
            s_q <= s_d;
        end
    end

    assign rsp = s_q.rsp;
    assign addr_out = s_q.addr;
    assign addr_out_oe = s_q.out_en;
    assign mem_data_o = s_q.wdata;
    assign mem_data_oe = s_q.out_en && (s_q.st == EMP_ST_STROBE) && s_q.write;
    assign program_space_sel_n = s_q.sel.program_space_sel_n;
    assign data_space_sel_n = s_q.sel.data_space_sel_n;
    assign xy_sel = s_q.sel.xy_sel;
    assign periph_space_sel_n = s_q.sel.periph_space_sel_n;
    assign rd_strobe_n = s_q.rd_n;
    assign wr_strobe_n = s_q.wr_n;
    assign ctrl_oe = s_q.out_en;

    property p_no_reserved;
        @(posedge sys_clk) disable iff (!nrst)
        !(!program_space_sel_n && !data_space_sel_n) &&
        !(program_space_sel_n && data_space_sel_n && !xy_sel);
    endproperty
    a_no_reserved: assert property (p_no_reserved) else $error("reserved select code");

    property p_idle_data_released;
        @(posedge sys_clk) disable iff (!nrst)
        (rd_strobe_n && wr_strobe_n) |-> !mem_data_oe;
    endproperty
    a_idle_data_released: assert property (p_idle_data_released) else $error("data driven idle");

    property p_addr_held;
        @(posedge sys_clk) disable iff (!nrst)
        (req_ready && !req.valid) |=> $stable(addr_out);
    endproperty
    a_addr_held: assert property (p_addr_held) else $error("address moved while idle");

    property p_write_drives;
        @(posedge sys_clk) disable iff (!nrst)
        !wr_strobe_n |-> (mem_data_oe && rd_strobe_n);
    endproperty
    a_write_drives: assert property (p_write_drives) else $error("write without data drive");

    property p_read_capture;
        @(posedge sys_clk) disable iff (!nrst)
        ($rose(rd_strobe_n) && s_q.st == EMP_ST_DONE) |->
            rsp.rdata == $past(mem_data_i);
    endproperty
    a_read_capture: assert property (p_read_capture) else $error("read data not captured");

    property p_strobe_width;
        @(posedge sys_clk) disable iff (!nrst)
        $fell(rd_strobe_n) |-> !rd_strobe_n [*2] ##1 rd_strobe_n;
    endproperty
    a_strobe_width: assert property (p_strobe_width) else $error("read strobe width wrong");

    property p_idle_selects_high;
        @(posedge sys_clk) disable iff (!nrst)
        (s_q.st == EMP_ST_IDLE && ctrl_oe) |->
            (program_space_sel_n && data_space_sel_n);
    endproperty
    a_idle_selects_high: assert property (p_idle_selects_high) else $error("select on idle");

    property p_periph;
        @(posedge sys_clk) disable iff (!nrst)
        !periph_space_sel_n |-> (!data_space_sel_n && !xy_sel && addr_out >= `EMP_PERIPH_LO);
    endproperty
    a_periph: assert property (p_periph) else $error("peripheral select outside Y I/O");

    property p_reset_tristate;
        @(posedge sys_clk) !nrst |=> (!addr_out_oe && !ctrl_oe && !mem_data_oe);
    endproperty
    a_reset_tristate: assert property (p_reset_tristate) else $error("pins driven in reset");

    property p_take_selects;
        @(posedge sys_clk) disable iff (!nrst)
        (req.valid && req_ready) |=>
            (addr_out == $past(req.addr)) && (program_space_sel_n != data_space_sel_n);
    endproperty
    a_take_selects: assert property (p_take_selects) else $error("selects not with address");

    property p_access_timing;
        @(posedge sys_clk) disable iff (!nrst)
        (req.valid && req_ready) |=>
            (!rd_strobe_n || !wr_strobe_n) [*2] ##1 (rd_strobe_n && wr_strobe_n) ##1 rsp.done;
    endproperty
    a_access_timing: assert property (p_access_timing) else $error("access timing wrong");

    property p_done_idle;
        @(posedge sys_clk) disable iff (!nrst)
        rsp.done |->
            (program_space_sel_n && data_space_sel_n && xy_sel && periph_space_sel_n && req_ready);
    endproperty
    a_done_idle: assert property (p_done_idle) else $error("selects active after access");

endmodule

`default_nettype wire

// >>> testbench/emp_ext_mem.sv
// Behavioural external static memory that sits on the far side of the port.
// Assumes the testbench resolves the shared data bus from both drivers.
`timescale 1ns/1ps
`default_nettype none

module emp_ext_mem (
    // Clock.
    input wire logic sys_clk,
    // Port pins.
    input wire logic [15:0] addr_out,
    input wire logic program_space_sel_n,
    input wire logic xy_sel,
    input wire logic rd_strobe_n,
    input wire logic wr_strobe_n,
    input wire logic [23:0] wr_data,
    // Value this memory puts on the data bus.
    output logic [23:0] rd_data
);
    logic [23:0] mem [0:63];
    logic [23:0] junk = 24'h0;
    logic [5:0] key;
    // Preset contents let every read be checked from the first access on.
    initial begin
        for (int i = 0; i < 64; i++) begin
            mem[i] = {18'h0, 6'(i)};
        end
    end
    assign key = {program_space_sel_n, xy_sel, addr_out[3:0]};
    // A released bus shows a pattern that changes every cycle.
    always @(posedge sys_clk) begin
        junk <= junk + 24'h3F1;
        if (!wr_strobe_n) begin
            mem[key] <= wr_data;
        end
    end
    assign rd_data = !rd_strobe_n ? mem[key] : junk;
endmodule

`default_nettype wire

// >>> testbench/tb_external_memory_port.sv
// Self-checking bench for the external memory port with random accesses.
// Assumes the port and the behavioural memory model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module tb_external_memory_port;
    import emp_pkg::*;
    logic sys_clk = 1'h0;
    logic nrst = 1'h0;
    logic dev_mode = 1'h0;
    emp_req_t req = '0;
    emp_rsp_t rsp;
    emp_sel_t sel, es;
    logic ps_n, ds_n, xy, px_n;
    logic req_ready, addr_out_oe, mem_data_oe, rd_strobe_n, wr_strobe_n, ctrl_oe;
    logic [15:0] addr_out;
    logic [23:0] mem_data_i, mem_data_o, mem_rd;
    logic [23:0] shadow [0:63];
    logic [31:0] seed = 32'h404D;
    int err_count = 0;
    int n_tests = 0;
    int cyc = 0;
    always #10 sys_clk = ~sys_clk;
    assign mem_data_i = mem_data_oe ? mem_data_o : mem_rd;
    assign sel = {ps_n, ds_n, xy, px_n};
    emp_port dut (.sys_clk, .nrst, .req, .dev_mode, .rsp, .req_ready, .addr_out,
        .addr_out_oe, .mem_data_i, .mem_data_o, .mem_data_oe,
        .program_space_sel_n(ps_n), .xy_sel(xy),
        .data_space_sel_n(ds_n), .rd_strobe_n, .wr_strobe_n,
        .periph_space_sel_n(px_n), .ctrl_oe);
    emp_ext_mem ext (.sys_clk, .addr_out, .program_space_sel_n(ps_n),
        .xy_sel(xy), .rd_strobe_n, .wr_strobe_n, .wr_data(mem_data_i),
        .rd_data(mem_rd));
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function emp_sel_t exp_sel(emp_req_t r, logic dm);
        exp_sel = 4'hF;
        if (r.space == EMP_SP_PROG) begin
            exp_sel.program_space_sel_n = 1'h0;
            exp_sel.xy_sel = !(r.vector_fetch && dm);
        end else begin
            exp_sel.data_space_sel_n = 1'h0;
            exp_sel.xy_sel = r.space == EMP_SP_X;
            exp_sel.periph_space_sel_n = !(r.space == EMP_SP_Y && r.addr >= 16'hFFC0);
        end
    endfunction
    task chk(logic [23:0] a, logic [23:0] e);
        n_tests++;
        if (a !== e) begin
            err_count++;
            $display("FAIL %0t value %h expected %h", $time, a, e);
        end
    endtask
    task chk_s(emp_sel_t a, emp_sel_t e);
        n_tests++;
        if (a !== e) begin
            err_count++;
            $display("FAIL %0t selects %b expected %b", $time, a, e);
        end
    endtask
    task final_report();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Runs one access from a falling edge and leaves valid high for chaining.
    task access(emp_req_t r, logic dm);
        logic [5:0] k;
        es = exp_sel(r, dm);
        k = {es.program_space_sel_n, es.xy_sel, r.addr[3:0]};
        dev_mode <= dm;
        req <= r;
        for (int i = 0; i < 50 && !req_ready; i++) @(negedge sys_clk);
        @(negedge sys_clk);
        chk_s(sel, es);
        chk({addr_out, rd_strobe_n, wr_strobe_n}, {r.addr, r.write, !r.write});
        chk({mem_data_oe, req_ready}, {r.write, 1'h0});
        if (r.write) chk(mem_data_o, r.wdata);
        @(negedge sys_clk);
        chk({rd_strobe_n, wr_strobe_n}, {r.write, !r.write});
        @(negedge sys_clk);
        chk({rd_strobe_n, wr_strobe_n, mem_data_oe}, 3'h6);
        chk_s(sel, es);
        @(negedge sys_clk);
        chk_s(sel, 4'hF);
        chk({rsp.done, req_ready, addr_out, mem_data_oe}, {2'h3, r.addr, 1'h0});
        if (r.write) begin
            shadow[k] = r.wdata;
        end else begin
            chk(rsp.rdata, shadow[k]);
        end
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            $display("FAIL %0t timeout", $time);
            final_report();
        end
    end
    initial begin
        emp_req_t r;
        for (int j = 0; j < 64; j++) shadow[j] = {18'h0, 6'(j)};
        repeat (10) @(negedge sys_clk);
        chk({addr_out_oe, ctrl_oe, mem_data_oe}, 3'h0);
        nrst <= 1'h1;
        @(negedge sys_clk);
        chk({addr_out_oe, ctrl_oe, mem_data_oe, req_ready}, 4'hD);
        chk(addr_out, 16'h0000);
        $display("reset test done");
        for (int i = 0; i < 120; i++) begin
            if (i == 60) begin
                req.valid <= 1'h0;
                nrst <= 1'h0;
                repeat (3) @(negedge sys_clk);
                chk({addr_out_oe, ctrl_oe, mem_data_oe, rsp.done}, 4'h0);
                nrst <= 1'h1;
                $display("mid-run reset test done");
            end
            r.valid = 1'h1;
            r.write = rnd() % 3 == 0;
            r.space = emp_space_t'(rnd() % 3);
            r.vector_fetch = 1'(rnd());
            r.addr = 16'(rnd());
            r.wdata = 24'(rnd());
            if (i % 2) r.addr[15:6] = 10'h3FF;
            if (i % 8 == 2) r.addr = 16'hFFBF;
            access(r, 1'(rnd()));
            if (rnd() % 2) begin
                req.valid <= 1'h0;
                @(negedge sys_clk);
            end
        end
        req.valid <= 1'h0;
        repeat (5) @(negedge sys_clk);
        chk({addr_out_oe, mem_data_oe, addr_out}, {2'h2, r.addr});
        $display("random access test done");
        final_report();
    end
endmodule

`default_nettype wire
